// ==== fault_loop_locator_trigger_defs.vh ====
// register offsets, field positions, reset values, record depth and divider width of the fault locator trigger
`ifndef FAULT_LOOP_LOCATOR_TRIGGER_DEFS_VH
`define FAULT_LOOP_LOCATOR_TRIGGER_DEFS_VH
// byte addresses of the register words
`define REG_CTRL 8'h00
`define REG_TRIG_CUR 8'h04
`define REG_XPERLEN 8'h08
`define REG_STATUS 8'h0C
`define REG_IRQ_STAT 8'h10
`define REG_IRQ_MASK 8'h14
`define REG_TRIG_CNT 8'h18
`define REG_REC_SEL 8'h1C
`define REG_REC_TIME 8'h20
`define REG_REC_INFO 8'h24
`define REG_REC_REACT 8'h28
`define REG_REC_CUR 8'h2C
`define REG_REC_PRI 8'h30
`define REG_REC_DIST 8'h34
`define REG_REC_COUNT 8'h38
// control register fields
`define CTRL_SRC_LSB 0
`define CTRL_SRC_MSB 4
`define CTRL_MASK_LSB 8
`define CTRL_MASK_MSB 15
`define CTRL_ENA_BIT 16
`define CTRL_CNT_CLR_BIT 17
`define CTRL_RESET 32'h0001_0000
// trigger current in tenths of nominal, 0..400
`define TRIG_CUR_MAX 12'h190
`define TRIG_CUR_RESET 12'h00A
// reactance per length in milliohm per km, 0..5000
`define XPERLEN_MAX 13'h1388
`define XPERLEN_RESET 13'h007D
// loop codes
`define LOOP_NONE 3'h0
`define LOOP_L1_L2 3'h1
`define LOOP_L2_L3 3'h2
`define LOOP_L3_L1 3'h3
`define LOOP_L1_N 3'h4
`define LOOP_L2_N 3'h5
`define LOOP_L3_N 3'h6
`define LOOP_L1_L2_L3 3'h7
// event storage choices
`define STORE_ON_BIT 0
`define STORE_OFF_BIT 1
`define STORE_RESET 2'h3
// interrupt status bits
`define IRQ_TRIG_BIT 0
`define IRQ_CALC_BIT 1
`define IRQ_BLK_BIT 2
`define IRQ_NOLOOP_BIT 3
`define REC_DEPTH 12
`define DIV_WIDTH 18
`endif

// ==== fault_loop_locator_trigger.v ====
// fault locator trigger: loop selection, distance, events, counter and record ring
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fault_loop_locator_trigger_defs.vh"
module fault_loop_locator_trigger (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg wb_ack_o,
  output wire irq_o,
  input wire [31:0] trig_sources_i,
  input wire [7:0] inhibit_sources_i,
  input wire block_i,
  input wire pe_volt_avail_i,
  input wire [11:0] current_l1_i,
  input wire [11:0] current_l2_i,
  input wire [11:0] current_l3_i,
  input wire [15:0] loop_reactance_l1_l2_i,
  input wire [15:0] loop_reactance_l2_l3_i,
  input wire [15:0] loop_reactance_l3_l1_i,
  input wire [15:0] loop_reactance_l1_n_i,
  input wire [15:0] loop_reactance_l2_n_i,
  input wire [15:0] loop_reactance_l3_n_i,
  input wire [1:0] direction_i,
  input wire [2:0] setting_group_i,
  input wire [15:0] ct_primary_ratio_i,
  input wire [31:0] time_ms_i,
  input wire [1:0] store_triggered_i,
  input wire [1:0] store_calc_i,
  input wire cycle_tick_i,
  output reg event_valid_o,
  output reg [1:0] event_code_o,
  output reg [31:0] event_time_o,
  output reg blocked_o,
  output reg triggered_o,
  output reg calc_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_DIV = 2'd1;
  localparam ST_STORE = 2'd2;

  reg [31:0] trig_s1_r, trig_s2_r;
  reg [7:0] inh_s1_r, inh_s2_r;
  reg blk_s1_r, blk_s2_r, pev_s1_r, pev_s2_r;
  reg src_prev_r, blk_cycle_r;
  reg [31:0] ctrl_r;
  reg [11:0] trig_cur_r;
  reg [12:0] xperlen_r;
  reg [3:0] irq_stat_r, irq_mask_r;
  reg [31:0] trig_cnt_r;
  reg [3:0] rec_sel_r, wr_ptr_r, rec_count_r;
  reg [1:0] state_r;
  reg [2:0] loop_r;
  reg [15:0] react_r;
  reg [11:0] icur_r;
  reg [31:0] quot_r, rem_r;
  reg [4:0] bit_r;
  reg [1:0] dir_r;
  reg [2:0] grp_r;
  reg [31:0] tstamp_r;
  reg [31:0] mem_time [0:`REC_DEPTH-1];
  reg [15:0] mem_info [0:`REC_DEPTH-1];
  reg [15:0] mem_react [0:`REC_DEPTH-1];
  reg [11:0] mem_cur [0:`REC_DEPTH-1];
  reg [27:0] mem_pri [0:`REC_DEPTH-1];
  reg [31:0] mem_dist [0:`REC_DEPTH-1];
  reg [2:0] loop_nxt;
  reg [15:0] react_nxt;
  reg [11:0] icur_nxt;
  reg [3:0] irq_set_r;
  reg [31:0] rd_data;
  reg [3:0] rd_idx;
  integer k;

  wire src_now = trig_s2_r[ctrl_r[`CTRL_SRC_MSB:`CTRL_SRC_LSB]];
  wire trig_edge = src_now & ~src_prev_r;
  wire inhibited = |(inh_s2_r & ctrl_r[`CTRL_MASK_MSB:`CTRL_MASK_LSB]);
  wire enabled = ctrl_r[`CTRL_ENA_BIT];
  wire o1 = current_l1_i > trig_cur_r;
  wire o2 = current_l2_i > trig_cur_r;
  wire o3 = current_l3_i > trig_cur_r;
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // a write lands at the edge where the master sees ack high
  wire bus_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & (&wb_sel_i[3:0]);
  wire [31:0] sub = {rem_r[30:0], quot_r[31]} - {19'h0, xperlen_r};
  wire [2:0] trig_ev = {o1, o2, o3};

  // loop choice; the three-phase case is recorded as LOOP_L1_L2_L3 with the L1-L2 reactance and L1 current
  always @* begin
    loop_nxt = `LOOP_NONE;
    react_nxt = 16'h0000;
    icur_nxt = 12'h000;
    case (trig_ev)
      3'b111: begin
        loop_nxt = `LOOP_L1_L2_L3;
        react_nxt = loop_reactance_l1_l2_i;
        icur_nxt = current_l1_i;
      end
      3'b110: begin
        loop_nxt = `LOOP_L1_L2;
        react_nxt = loop_reactance_l1_l2_i;
        icur_nxt = current_l1_i;
      end
      3'b011: begin
        loop_nxt = `LOOP_L2_L3;
        react_nxt = loop_reactance_l2_l3_i;
        icur_nxt = current_l2_i;
      end
      3'b101: begin
        loop_nxt = `LOOP_L3_L1;
        react_nxt = loop_reactance_l3_l1_i;
        icur_nxt = current_l3_i;
      end
      3'b100: begin
        if (pev_s2_r) begin
          loop_nxt = `LOOP_L1_N;
          react_nxt = loop_reactance_l1_n_i;
          icur_nxt = current_l1_i;
        end
      end
      3'b010: begin
        if (pev_s2_r) begin
          loop_nxt = `LOOP_L2_N;
          react_nxt = loop_reactance_l2_n_i;
          icur_nxt = current_l2_i;
        end
      end
      3'b001: begin
        if (pev_s2_r) begin
          loop_nxt = `LOOP_L3_N;
          react_nxt = loop_reactance_l3_n_i;
          icur_nxt = current_l3_i;
        end
      end
      default: begin
        loop_nxt = `LOOP_NONE;
      end
    endcase
  end

  // trigger, inhibit, block and pe_volt_avail_i inputs pass two flops first
  always @(posedge clk_i) begin
    if (rst_i) begin
      trig_s1_r <= 32'h0000_0000;
      trig_s2_r <= 32'h0000_0000;
      inh_s1_r <= 8'h00;
      inh_s2_r <= 8'h00;
      blk_s1_r <= 1'b0;
      blk_s2_r <= 1'b0;
      pev_s1_r <= 1'b0;
      pev_s2_r <= 1'b0;
    end else begin
      trig_s1_r <= trig_sources_i;
      trig_s2_r <= trig_s1_r;
      inh_s1_r <= inhibit_sources_i;
      inh_s2_r <= inh_s1_r;
      blk_s1_r <= block_i;
      blk_s2_r <= blk_s1_r;
      pev_s1_r <= pe_volt_avail_i;
      pev_s2_r <= pev_s1_r;
    end
  end

  // main sequence
  always @(posedge clk_i) begin
    irq_set_r <= 4'h0;
    if (rst_i) begin
      src_prev_r <= 1'b0;
      blk_cycle_r <= 1'b0;
      state_r <= ST_IDLE;
      loop_r <= `LOOP_NONE;
      react_r <= 16'h0000;
      icur_r <= 12'h000;
      quot_r <= 32'h0000_0000;
      rem_r <= 32'h0000_0000;
      bit_r <= 5'h00;
      dir_r <= 2'h0;
      grp_r <= 3'h0;
      tstamp_r <= 32'h0000_0000;
      wr_ptr_r <= 4'h0;
      rec_count_r <= 4'h0;
      trig_cnt_r <= 32'h0000_0000;
      blocked_o <= 1'b0;
      triggered_o <= 1'b0;
      calc_o <= 1'b0;
      event_valid_o <= 1'b0;
      event_code_o <= 2'h0;
      event_time_o <= 32'h0000_0000;
    end else begin
      event_valid_o <= 1'b0;
      if (cycle_tick_i)
        blk_cycle_r <= blk_s2_r;
      if (trig_edge | ~src_now)
        src_prev_r <= src_now;
      // falling source ends the triggered indication, after the record so events never collide
      if (~src_now & triggered_o & state_r == ST_IDLE & ~calc_o) begin
        triggered_o <= 1'b0;
        blocked_o <= 1'b0;
        if (store_triggered_i[`STORE_OFF_BIT]) begin
          event_valid_o <= 1'b1;
          event_code_o <= 2'h1;
          event_time_o <= time_ms_i;
        end
      end else if (~src_now & blocked_o) begin
        blocked_o <= 1'b0;
      end
      if (calc_o) begin
        calc_o <= 1'b0;
        if (store_calc_i[`STORE_OFF_BIT]) begin
          event_valid_o <= 1'b1;
          event_code_o <= 2'h3;
          event_time_o <= time_ms_i;
        end
      end
      case (state_r)
        ST_IDLE: begin
          // an edge in the calculation OFF cycle is refused, its event slot is taken
          if (trig_edge & enabled & ~calc_o) begin
            if (blk_cycle_r) begin
              blocked_o <= 1'b1;
              irq_set_r[`IRQ_BLK_BIT] <= 1'b1;
            end else begin
              triggered_o <= 1'b1;
              trig_cnt_r <= trig_cnt_r + 32'h0000_0001;
              irq_set_r[`IRQ_TRIG_BIT] <= 1'b1;
              if (store_triggered_i[`STORE_ON_BIT]) begin
                event_valid_o <= 1'b1;
                event_code_o <= 2'h0;
                event_time_o <= time_ms_i;
              end
              if (inhibited) begin
                irq_set_r[`IRQ_NOLOOP_BIT] <= 1'b1;
              end else if (loop_nxt == `LOOP_NONE) begin
                irq_set_r[`IRQ_NOLOOP_BIT] <= 1'b1;
              end else begin
                // loop inputs, direction, group and time are frozen here; xperlen_r and ct_primary_ratio_i are still read live
                loop_r <= loop_nxt;
                react_r <= react_nxt;
                icur_r <= icur_nxt;
                dir_r <= direction_i;
                grp_r <= setting_group_i;
                tstamp_r <= time_ms_i;
                rem_r <= 32'h0000_0000;
                quot_r <= {react_nxt, 16'h0000};
                bit_r <= 5'h1F;
                state_r <= (xperlen_r == 13'h0000) ? ST_STORE : ST_DIV;
              end
            end
          end
        end
        ST_DIV: begin
          // restoring divide, one quotient bit per clock
          if (sub[31] == 1'b0) begin
            rem_r <= sub;
            quot_r <= {quot_r[30:0], 1'b1};
          end else begin
            rem_r <= {rem_r[30:0], quot_r[31]};
            quot_r <= {quot_r[30:0], 1'b0};
          end
          if (bit_r == 5'h00)
            state_r <= ST_STORE;
          bit_r <= bit_r - 5'h01;
        end
        ST_STORE: begin
          mem_time[wr_ptr_r] <= tstamp_r;
          mem_info[wr_ptr_r] <= {6'h00, grp_r, dir_r, 2'h1, loop_r};
          mem_react[wr_ptr_r] <= react_r;
          mem_cur[wr_ptr_r] <= icur_r;
          mem_pri[wr_ptr_r] <= icur_r * ct_primary_ratio_i;
          mem_dist[wr_ptr_r] <= (xperlen_r == 13'h0000) ? 32'hFFFF_FFFF : quot_r;
          wr_ptr_r <= (wr_ptr_r == `REC_DEPTH - 1) ? 4'h0 : wr_ptr_r + 4'h1;
          if (rec_count_r != `REC_DEPTH)
            rec_count_r <= rec_count_r + 4'h1;
          calc_o <= 1'b1;
          irq_set_r[`IRQ_CALC_BIT] <= 1'b1;
          if (store_calc_i[`STORE_ON_BIT]) begin
            event_valid_o <= 1'b1;
            event_code_o <= 2'h2;
            event_time_o <= tstamp_r;
          end
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
      if (bus_wr & wb_adr_i == `REG_CTRL & wb_dat_i[`CTRL_CNT_CLR_BIT])
        trig_cnt_r <= 32'h0000_0000;
    end
  end

  // register file; a read of the interrupt status clears it, new events win
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `CTRL_RESET;
      trig_cur_r <= `TRIG_CUR_RESET;
      xperlen_r <= `XPERLEN_RESET;
      irq_mask_r <= 4'h0;
      irq_stat_r <= 4'h0;
      rec_sel_r <= 4'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req & ~wb_we_i)
        wb_dat_o <= rd_data;
      if (bus_req & ~wb_we_i & wb_adr_i == `REG_IRQ_STAT)
        irq_stat_r <= irq_set_r;
      else
        irq_stat_r <= irq_stat_r | irq_set_r;
      if (bus_wr) begin
        case (wb_adr_i)
          `REG_CTRL: ctrl_r <= {15'h0000, wb_dat_i[16:0] & 17'h1FF1F};
          `REG_TRIG_CUR: trig_cur_r <= (wb_dat_i[11:0] > `TRIG_CUR_MAX) ?
                                       `TRIG_CUR_MAX : wb_dat_i[11:0];
          `REG_XPERLEN: xperlen_r <= (wb_dat_i[12:0] > `XPERLEN_MAX) ?
                                     `XPERLEN_MAX : wb_dat_i[12:0];
          `REG_IRQ_MASK: irq_mask_r <= wb_dat_i[3:0];
          `REG_REC_SEL: rec_sel_r <= (wb_dat_i[3:0] > 4'hB) ? 4'hB : wb_dat_i[3:0];
          default: ;
        endcase
      end
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // rec_sel 0 is the newest record
  always @* begin
    rd_idx = (wr_ptr_r > rec_sel_r) ? wr_ptr_r - rec_sel_r - 4'h1 :
             wr_ptr_r + 4'hB - rec_sel_r;
    case (wb_adr_i)
      `REG_CTRL: rd_data = ctrl_r;
      `REG_TRIG_CUR: rd_data = {20'h00000, trig_cur_r};
      `REG_XPERLEN: rd_data = {19'h00000, xperlen_r};
      `REG_STATUS: rd_data = {24'h000000, state_r, pev_s2_r, blk_cycle_r,
                              calc_o, blocked_o, triggered_o, src_now};
      `REG_IRQ_STAT: rd_data = {28'h0000000, irq_stat_r};
      `REG_IRQ_MASK: rd_data = {28'h0000000, irq_mask_r};
      `REG_TRIG_CNT: rd_data = trig_cnt_r;
      `REG_REC_SEL: rd_data = {28'h0000000, rec_sel_r};
      `REG_REC_TIME: rd_data = mem_time[rd_idx];
      `REG_REC_INFO: rd_data = {16'h0000, mem_info[rd_idx]};
      `REG_REC_REACT: rd_data = {16'h0000, mem_react[rd_idx]};
      `REG_REC_CUR: rd_data = {20'h00000, mem_cur[rd_idx]};
      `REG_REC_PRI: rd_data = {4'h0, mem_pri[rd_idx]};
      `REG_REC_DIST: rd_data = mem_dist[rd_idx];
      `REG_REC_COUNT: rd_data = {28'h0000000, rec_count_r};
      default: rd_data = 32'h0000_0000;
    endcase
    if (wb_adr_i >= `REG_REC_TIME & wb_adr_i <= `REG_REC_DIST & rec_sel_r >= rec_count_r)
      rd_data = 32'h0000_0000;
  end

  initial begin
    for (k = 0; k < `REC_DEPTH; k = k + 1) begin
      mem_time[k] = 32'h0000_0000;
      mem_info[k] = 16'h0000;
      mem_react[k] = 16'h0000;
      mem_cur[k] = 12'h000;
      mem_pri[k] = 28'h0000000;
      mem_dist[k] = 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ==== fault_loop_locator_trigger_props.sv ====
// concurrent checks on the fault locator trigger ports
`timescale 1ns/1ps
`default_nettype none
module fault_loop_locator_trigger_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic event_valid_o,
  input wire logic [1:0] event_code_o,
  input wire logic [1:0] store_triggered_i,
  input wire logic [1:0] store_calc_i,
  input wire logic triggered_o,
  input wire logic calc_o,
  input wire logic blocked_o
);
  logic [2:0] calc_hist_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // calculation events may trail the strobe, so keep a short history of it
  always_ff @(posedge clk_i) begin
    calc_hist_r <= rst_i ? 3'h0 : {calc_hist_r[1:0], calc_o};
  end
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ev(logic [1:0] code);
    event_valid_o && event_code_o == code;
  endsequence
  a_ack_answer: assert property (s_take |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_trig_event: assert property (s_ev(2'h0) |-> ##[0:2] triggered_o)
    else $error("trigger on event without trigger");
  a_calc_pulse: assert property (calc_o |=> !calc_o)
    else $error("calculation flag longer than one cycle");
  a_calc_on_event: assert property (s_ev(2'h2) |-> ##[0:1] (calc_o || calc_hist_r != 3'h0))
    else $error("calculation on event without calculation");
  a_calc_off_event: assert property (s_ev(2'h3) |-> calc_hist_r != 3'h0)
    else $error("calculation off event out of place");
  a_block_excl: assert property (blocked_o |-> !triggered_o && !calc_o)
    else $error("blocked situation still processed");
  a_event_filter: assert property (event_valid_o |-> (event_code_o[1] ?
    store_calc_i[event_code_o[0]] : store_triggered_i[event_code_o[0]]))
    else $error("event emitted against store choice");
endmodule
`default_nettype wire

// ==== protection_source_model.sv ====
// behavioural protection side: trigger sources, blocking matrix output, program cycle tick
`timescale 1ns/1ps
`default_nettype none
module protection_source_model #(
  parameter int TICK_DIV = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] src_sel_i,
  input wire logic operate_i,
  input wire logic block_req_i,
  input wire logic [31:0] noise_i,
  output logic [31:0] trig_sources_o,
  output logic block_o,
  output logic cycle_tick_o
);
  logic [7:0] div_r;
  logic [31:0] onehot;
  assign onehot = 32'h1 << src_sel_i;
  always_ff @(posedge clk_i) begin
    div_r <= (rst_i || div_r == TICK_DIV - 1) ? 8'h00 : div_r + 8'h01;
    cycle_tick_o <= !rst_i && div_r == 8'h00;
    // unselected sources toggle freely, only the chosen one may trigger
    trig_sources_o <= (noise_i & ~onehot) | (operate_i ? onehot : 32'h0);
    // block moves only on a program cycle, well ahead of the pick-up that follows
    if (rst_i) begin
      block_o <= 1'b0;
    end else if (cycle_tick_o) begin
      block_o <= block_req_i;
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench: bus reads and events are noted in queues and checked by a monitor
`timescale 1ns/1ps
`default_nettype none
`include "fault_loop_locator_trigger_defs.vh"
module tb_top;
  typedef struct {string name; logic [31:0] exp;} note_t;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic [7:0] adr = 8'h00, inh = 8'h00;
  logic [31:0] wdat = 32'h0, tms = 32'h0, noise = 32'h0, rdat, trig_src, ev_time;
  logic [3:0] sel = 4'hF;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, pe = 1'b0, op = 1'b0, breq = 1'b0;
  logic ack, irq, blk, tick, ev_valid, blocked, trig, calc;
  logic [11:0] cur [3];
  logic [15:0] xr [8];
  logic [1:0] dir = 2'h0, st = 2'h0, sc = 2'h0, ev_code;
  logic [2:0] grp = 3'h0;
  logic [4:0] src = 5'h00;
  logic [12:0] xper = 13'h007D;
  logic [31:0] rnd = 32'h62;
  logic [6:0] cases [9] = '{7'h7F, 7'h31, 7'h6A, 7'h53, 7'h1C, 7'h2D, 7'h4E, 7'h10, 7'h08};
  note_t rd_q[$];
  logic [1:0] ev_q[$];
  int mismatches = 0, checked = 0, n_rec = 0, n_trig = 0;
  fault_loop_locator_trigger u_fault_loop_locator_trigger (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we),
    .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .irq_o(irq),
    .trig_sources_i(trig_src), .inhibit_sources_i(inh), .block_i(blk), .pe_volt_avail_i(pe),
    .current_l1_i(cur[0]), .current_l2_i(cur[1]), .current_l3_i(cur[2]),
    .loop_reactance_l1_l2_i(xr[1]), .loop_reactance_l2_l3_i(xr[2]), .loop_reactance_l3_l1_i(xr[3]),
    .loop_reactance_l1_n_i(xr[4]), .loop_reactance_l2_n_i(xr[5]), .loop_reactance_l3_n_i(xr[6]),
    .direction_i(dir), .setting_group_i(grp), .ct_primary_ratio_i(16'h0064), .time_ms_i(tms),
    .store_triggered_i(st), .store_calc_i(sc), .cycle_tick_i(tick), .event_valid_o(ev_valid),
    .event_code_o(ev_code), .event_time_o(ev_time), .blocked_o(blocked), .triggered_o(trig),
    .calc_o(calc));
  protection_source_model u_protection_source_model (.clk_i(clk_i), .rst_i(rst_i),
    .src_sel_i(src), .operate_i(op), .block_req_i(breq), .noise_i(noise),
    .trig_sources_o(trig_src), .block_o(blk), .cycle_tick_o(tick));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) noise <= ~noise ^ rnd;
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back('{name, exp});
    wb(1'b0, a, 32'h0);
  endtask
  // currents sit at the default threshold of ten tenths or one step above it
  task automatic fire(input logic [6:0] c, input logic [3:0] s, input logic b);
    logic rec;
    rec = c[2:0] != 3'h0;
    for (int k = 0; k < 3; k++)
      cur[k] <= c[4 + k] ? 12'h00B : 12'h00A;
    pe <= c[3];
    st <= s[1:0];
    sc <= s[3:2];
    dir <= 2'(xs() % 3);
    grp <= 3'(xs());
    tms <= xs();
    for (int k = 1; k < 7; k++)
      xr[k] <= 16'(xs());
    if (s[0]) ev_q.push_back(2'h0);
    if (rec && s[2]) ev_q.push_back(2'h2);
    if (rec && s[3]) ev_q.push_back(2'h3);
    if (s[1]) ev_q.push_back(2'h1);
    repeat (4) @(posedge clk_i);
    op <= 1'b1;
    repeat (60) @(posedge clk_i);
    chk("blocked", {31'h0, blocked}, {31'h0, b});
    op <= 1'b0;
    repeat (12) @(posedge clk_i);
    n_trig += !b;
    n_rec += rec && !b;
    if (n_rec > 12) n_rec = 12;
  endtask
  task automatic check_rec(input logic [6:0] c);
    logic [15:0] x;
    x = xr[c[2:0] == 3'h7 ? 3'h1 : c[2:0]];
    rd("rec count", `REG_REC_COUNT, n_rec);
    rd("trig count", `REG_TRIG_CNT, n_trig);
    if (c[2:0] != 3'h0) begin
      rd("rec info", `REG_REC_INFO, {22'h0, grp, dir, 2'h1, c[2:0]});
      rd("rec time", `REG_REC_TIME, tms);
      rd("rec dist", `REG_REC_DIST, {x, 16'h0} / xper);
      rd("rec react", `REG_REC_REACT, {16'h0, x});
      rd("rec cur", `REG_REC_CUR, 32'h0000_000B);
      rd("rec pri", `REG_REC_PRI, 32'h0000_044C);
    end
  endtask
  always @(posedge clk_i) begin
    note_t n;
    if (ack === 1'b1 && we === 1'b0) begin
      n = rd_q.pop_front();
      chk(n.name, rdat, n.exp);
    end
    if (ev_valid === 1'b1 && ev_q.size() == 0) chk("extra event", 32'h1, 32'h0);
    else if (ev_valid === 1'b1) begin
      chk("event code", 32'(ev_code), 32'(ev_q.pop_front()));
      chk("event time", ev_time, tms);
    end
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    mismatches++;
    summarize();
  end
  initial begin
    for (int k = 0; k < 8; k++) xr[k] = 16'h0000;
    for (int k = 0; k < 3; k++) cur[k] = 12'h000;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("ctrl", `REG_CTRL, `CTRL_RESET);
    rd("trig cur", `REG_TRIG_CUR, 32'(`TRIG_CUR_RESET));
    rd("x per len", `REG_XPERLEN, 32'(`XPERLEN_RESET));
    sel <= 4'h3;
    wr(`REG_TRIG_CUR, 32'h0000_0001);
    sel <= 4'hF;
    rd("partial write", `REG_TRIG_CUR, 32'h0000_000A);
    rd("unmapped", 8'h3C, 32'h0);
    $display("test reset values done");
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 9; i++) begin
        // disabled while the source moves, the old one turns to noise in the partner
        wr(`REG_CTRL, 32'h0);
        src <= 5'(xs());
        repeat (4) @(posedge clk_i);
        wr(`REG_CTRL, {15'h0, 1'b1, 8'h00, 3'h0, src});
        fire(cases[i], 4'(i * 5 + p), 1'b0);
        check_rec(cases[i]);
      end
      xper = 13'h1 + 13'(xs() % 32'd5000);
      wr(`REG_XPERLEN, 32'(xper));
      $display("test loop table done");
    end
    rd("irq stat", `REG_IRQ_STAT, 32'h0000_000B);
    wr(`REG_IRQ_MASK, 32'h1);
    fire(7'h7F, 4'h0, 1'b0);
    chk("irq", {31'h0, irq}, 32'h1);
    rd("irq stat", `REG_IRQ_STAT, 32'h3);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, irq}, 32'h0);
    breq <= 1'b1;
    repeat (20) @(posedge clk_i);
    fire(7'h7F, 4'h0, 1'b1);
    check_rec(7'h00);
    breq <= 1'b0;
    repeat (20) @(posedge clk_i);
    wr(`REG_CTRL, {15'h0, 1'b1, 8'h01, 3'h0, src});
    inh <= 8'h01;
    fire(7'h78, 4'h0, 1'b0);
    rd("rec count", `REG_REC_COUNT, n_rec);
    inh <= 8'h00;
    wr(`REG_CTRL, {14'h0, 2'h3, 8'h00, 3'h0, src});
    n_trig = 0;
    rd("trig count", `REG_TRIG_CNT, n_trig);
    $display("test irq block inhibit clear done");
    chk("queues empty", 32'(ev_q.size() + rd_q.size()), 32'h0);
    summarize();
  end
endmodule
bind fault_loop_locator_trigger fault_loop_locator_trigger_props u_fault_loop_locator_trigger_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .event_valid_o(event_valid_o), .event_code_o(event_code_o),
  .store_triggered_i(store_triggered_i), .store_calc_i(store_calc_i),
  .triggered_o(triggered_o), .calc_o(calc_o), .blocked_o(blocked_o));
`default_nettype wire
